// ### logic/cmp_filter.sv
// Synchroniser and two-sample digital filter for one comparator output
`timescale 1ns/1ps
module cmp_filter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic raw_in,
	input wire logic enable,
	input wire cmp_pkg::cmp_flt_t sel,
	input wire logic [2:0] tick,
	output logic level
);
	import cmp_pkg::*;

	typedef struct packed {
		logic s1; // First synchroniser stage, read only by s2
		logic s2;
		logic s3;
		logic sync_lv; // Level once s2 and s3 agree
		logic smp; // Previous filter sample
		logic lvl; // Accepted result
	} cmp_flt_st_t;

	cmp_flt_st_t s_r;
	cmp_flt_st_t s_nxt;
	logic tk;

	// Tick of the selected sampling rate
	always_comb begin
		unique case (sel)
			FLT_F2: tk = tick[0];
			FLT_F8: tk = tick[1];
			FLT_F32: tk = tick[2];
			FLT_NONE: tk = 1'b0;
		endcase
	end

	// Analog output is asynchronous: three stages, then filtering
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = raw_in; // [R21]
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		if (s_r.s2 == s_r.s3) begin
			s_nxt.sync_lv = s_r.s3; // [R21]
		end
		// A disabled channel holds its last result
		if (enable) begin
			if (sel == FLT_NONE) begin
				s_nxt.lvl = s_r.sync_lv; // [R7]
			end else if (tk) begin
				s_nxt.smp = s_r.sync_lv;
				// Accept only when two samples in a row match
				if (s_r.smp == s_r.sync_lv) begin
					s_nxt.lvl = s_r.sync_lv; // [R6]
				end
			end
		end
	end

	// State register; result starts high to match the reset image
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= {6{RESULT_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.lvl;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Unsettled synchroniser stages never move the level
	property p_sync_hold;
		(s_r.s2 != s_r.s3) |=> $stable(s_r.sync_lv);
	endproperty
	a_sync_hold: assert property (p_sync_hold) // [R21]
		else $error("sync level moved while stages disagree");

	// Filtered mode takes the level whenever two samples in a row match
	property p_two_match;
		enable && sel != FLT_NONE && tk && s_r.smp == s_r.sync_lv
			|=> level == $past(s_r.sync_lv);
	endproperty
	a_two_match: assert property (p_two_match) // [R6]
		else $error("filter did not accept two matching samples");

	// Level never changes without an accepting condition
	property p_no_spur;
		$changed(level) |-> $past(enable) &&
			($past(sel) == FLT_NONE || $past(tk));
	endproperty
	a_no_spur: assert property (p_no_spur) // [R6]
		else $error("filter level changed without sample");

	// Unfiltered mode follows the synchronised level
	property p_nofilt;
		enable && sel == FLT_NONE |=> level == $past(s_r.sync_lv);
	endproperty
	a_nofilt: assert property (p_nofilt) // [R7]
		else $error("no-filter mode does not follow input");
endmodule

// ### logic/cmp_pkg.sv
// Shared constants and carrier types for the dual comparator block
package cmp_pkg;
	// Channel count and bus geometry
	localparam int NCH = 2;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQC0 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQC1 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DAC = 8'h14;
	// Control register field positions
	localparam int B_EN = 0;
	localparam int B_OE = 1;
	localparam int B_REF = 2;
	localparam int B_LV = 3;
	localparam int B_FLT = 4;
	localparam int B_IE = 6;
	localparam int B_CF = 7;
	// Interrupt control field positions
	localparam int B_LVL = 0;
	localparam int B_IR = 3;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h08;
	localparam logic RESULT_RST = 1'b1;
	// Sampling divisions for the digital filter
	localparam int DIV_F2 = 2;
	localparam int DIV_F8 = 8;
	localparam int DIV_F32 = 32;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Filter selection codes
	typedef enum logic [1:0] {
		FLT_NONE = 2'h0,
		FLT_F2 = 2'h1,
		FLT_F8 = 2'h2,
		FLT_F32 = 2'h3
	} cmp_flt_t;
	// Master to slave half of AXI4-Lite
	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} cmp_axi_req_t;
	// Slave to master half of AXI4-Lite
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cmp_axi_rsp_t;
	// Per-channel signals toward the analog element and pins
	typedef struct packed {
		logic [NCH-1:0] compare_enable;
		logic [NCH-1:0] reference_select;
		logic [NCH-1:0] dac_output_enable;
		logic [NCH-1:0] result_output_pin;
		logic [NCH-1:0] result_output_pin_oe;
	} cmp_pins_t;
endpackage

// ### logic/cmp_prescale.sv
// Sampling tick generator for the f2, f8 and f32 filter rates
`timescale 1ns/1ps
module cmp_prescale #(
	parameter int CNT_W = 5
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic [2:0] tick
);
	import cmp_pkg::*;

	// Counter must reach the slowest division
	if ((1 << CNT_W) < DIV_F32) begin : g_chk
		$error("cmp_prescale: CNT_W too small");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt; // Free-running divider
		logic [2:0] tick; // One-cycle pulses, bit0 f2, bit1 f8, bit2 f32
	} cmp_ps_t;

	cmp_ps_t s_r;
	cmp_ps_t s_nxt;

	// Ticks pulse when the low divider bits are all ones
	always_comb begin
		s_nxt = s_r;
		s_nxt.cnt = s_r.cnt + 1'b1;
		s_nxt.tick[0] = &s_r.cnt[$clog2(DIV_F2)-1:0];
		s_nxt.tick[1] = &s_r.cnt[$clog2(DIV_F8)-1:0];
		s_nxt.tick[2] = &s_r.cnt[$clog2(DIV_F32)-1:0];
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// The fastest rate never pulses twice in a row
	property p_f2_rate;
		tick[0] |=> !tick[0] ##1 tick[0];
	endproperty
	a_f2_rate: assert property (p_f2_rate) // [R7]
		else $error("f2 tick spacing wrong");
endmodule

// ### logic/cmp_top.sv
// Dual comparator digital side: registers, flags, pins and interrupt gating
`timescale 1ns/1ps
// Operation
// R1: Two identical independent comparator channels
// R2: Result flag high when input above reference
// R3: Any result toggle sets change flag
// R4: Result pin driven only while enabled
// R5: Pin result optionally inverted by polarity
// R6: Filter accepts level after two matching samples
// R7: Filter select: none, f2, f8, f32
// R8: Reference select picks pin or DAC
// R9: Change flag and enable raise request
// R10: Pending set when flag and enable
// R11: Pending drops when either goes low
// R12: Acknowledge leaves change flag set
// R13: Flag clears on zero write after one-read
// R14: Request gated by level, threshold, global enable
// R15: Software sets polarity, filter, reference first
// R16: Software enables DAC output before channel
// R17: Software enables channel, waits settling time
// R18: Software dummy-reads change flag after wait
// R19: Software then enables pin, interrupt, clears flag
// R20: Software finally sets priority, clears pending
// R21: Analog output synchronised before filtering
module cmp_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cmp_pkg::cmp_axi_req_t axi_req,
	output cmp_pkg::cmp_axi_rsp_t axi_rsp,
	input wire logic [cmp_pkg::NCH-1:0] raw_compare_result,
	input wire logic global_irq_enable,
	input wire logic [2:0] current_priority_threshold,
	output cmp_pkg::cmp_pins_t pins,
	output logic [cmp_pkg::NCH-1:0] irq_req
);
	import cmp_pkg::*;

	typedef struct packed {
		logic aw_have; // Write address held
		logic [ADDR_W-1:0] aw_addr;
		logic w_have; // Write data held
		logic [7:0] w_data; // Only the low byte carries fields
		logic w_strb0;
		cmp_axi_rsp_t rsp; // All bus outputs come from here
		logic [NCH-1:0] en; // compare_enable
		logic [NCH-1:0] oe; // result_pin_output_enable
		logic [NCH-1:0] rsel; // reference_select
		logic [NCH-1:0][1:0] flt; // filter_select
		logic [NCH-1:0] ie; // compare_irq_enable
		logic [NCH-1:0] cf; // compare_change_flag
		logic [NCH-1:0] armed; // Flag read back as one since last write
		logic [NCH-1:0] lv_prev; // Result one cycle ago, for change detect
		logic [NCH-1:0] pol; // result_pin_polarity
		logic [NCH-1:0][2:0] prio; // priority_level
		logic [NCH-1:0] ir; // pending_request
		logic [NCH-1:0] dac_en; // dac_output_enable
		cmp_pins_t pins;
		logic [NCH-1:0] irq;
	} cmp_st_t;

	cmp_st_t s_r;
	cmp_st_t s_nxt;
	logic [NCH-1:0] lvl; // Filtered comparison result per channel
	logic [NCH-1:0] chg; // Result toggled this cycle
	logic [2:0] tick;
	logic do_wr; // Held address and data are written this cycle
	logic do_rd; // Read address accepted this cycle
	logic [ADDR_W-1:0] ctrl_ofs [NCH];
	logic [ADDR_W-1:0] irqc_ofs [NCH];

	assign ctrl_ofs[0] = OFS_CTRL0;
	assign ctrl_ofs[1] = OFS_CTRL1;
	assign irqc_ofs[0] = OFS_IRQC0;
	assign irqc_ofs[1] = OFS_IRQC1;

	// One shared sampling clock divider serves both channels
	cmp_prescale #(
		.CNT_W(5)
	) u_ps (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	// Each channel has its own filter and change detector
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		cmp_filter u_flt (
			.aclk(aclk),
			.aresetn(aresetn),
			.raw_in(raw_compare_result[g]),
			.enable(s_r.en[g]),
			.sel(cmp_flt_t'(s_r.flt[g])),
			.tick(tick),
			.level(lvl[g])
		); // [R1]
		// Either direction counts; the filter only moves while enabled,
		// so a toggle landing with a disable write still sets the flag
		assign chg[g] = lvl[g] != s_r.lv_prev[g]; // [R3]
	end

	assign do_wr = s_r.aw_have && s_r.w_have && !s_r.rsp.bvalid;
	assign do_rd = axi_req.arvalid && s_r.rsp.arready;

	// Register file, bus handshakes, flags and pin drive
	always_comb begin
		logic wr_hit;
		logic rd_hit;
		logic [31:0] rd;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		rd = '0;
		s_nxt = s_r;
		s_nxt.lv_prev = lvl;
		// Address and data channels are taken in either order
		if (axi_req.awvalid && s_r.rsp.awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_r.rsp.wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = axi_req.wdata[7:0];
			s_nxt.w_strb0 = axi_req.wstrb[0];
		end
		if (s_r.rsp.bvalid && axi_req.bready) begin
			s_nxt.rsp.bvalid = 1'b0;
		end
		// Register write once both halves are held
		if (do_wr) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			for (int c = 0; c < NCH; c++) begin
				if (s_r.aw_addr == ctrl_ofs[c]) begin
					wr_hit = 1'b1;
					s_nxt.armed[c] = 1'b0;
					if (s_r.w_strb0) begin
						s_nxt.en[c] = s_r.w_data[B_EN];
						s_nxt.oe[c] = s_r.w_data[B_OE];
						s_nxt.rsel[c] = s_r.w_data[B_REF];
						s_nxt.flt[c] = s_r.w_data[B_FLT+:2];
						s_nxt.ie[c] = s_r.w_data[B_IE];
						// Zero clears only after a one was read back
						if (!s_r.w_data[B_CF] && s_r.armed[c]) begin
							s_nxt.cf[c] = 1'b0; // [R13]
						end
					end
				end
				if (s_r.aw_addr == irqc_ofs[c]) begin
					wr_hit = 1'b1;
					// Pending follows flag and enable, so writes skip it
					if (s_r.w_strb0) begin
						s_nxt.prio[c] = s_r.w_data[B_LVL+:3];
					end
				end
			end
			if (s_r.aw_addr == OFS_MODE) begin
				wr_hit = 1'b1;
				if (s_r.w_strb0) begin
					s_nxt.pol = s_r.w_data[NCH-1:0];
				end
			end
			if (s_r.aw_addr == OFS_DAC) begin
				wr_hit = 1'b1;
				if (s_r.w_strb0) begin
					s_nxt.dac_en = s_r.w_data[NCH-1:0];
				end
			end
			s_nxt.rsp.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_r.rsp.rvalid && axi_req.rready) begin
			s_nxt.rsp.rvalid = 1'b0;
		end
		// Register read; a control read arms the flag clear
		if (do_rd) begin
			for (int c = 0; c < NCH; c++) begin
				if (axi_req.araddr == ctrl_ofs[c]) begin
					rd_hit = 1'b1;
					rd[B_EN] = s_r.en[c];
					rd[B_OE] = s_r.oe[c];
					rd[B_REF] = s_r.rsel[c];
					rd[B_LV] = lvl[c]; // [R2]
					rd[B_FLT+:2] = s_r.flt[c];
					rd[B_IE] = s_r.ie[c];
					rd[B_CF] = s_r.cf[c];
					s_nxt.armed[c] = s_r.cf[c]; // [R13]
				end
				if (axi_req.araddr == irqc_ofs[c]) begin
					rd_hit = 1'b1;
					rd[B_LVL+:3] = s_r.prio[c];
					rd[B_IR] = s_r.ir[c];
				end
			end
			if (axi_req.araddr == OFS_MODE) begin
				rd_hit = 1'b1;
				rd[NCH-1:0] = s_r.pol;
			end
			if (axi_req.araddr == OFS_DAC) begin
				rd_hit = 1'b1;
				rd[NCH-1:0] = s_r.dac_en;
			end
			s_nxt.rsp.rvalid = 1'b1;
			s_nxt.rsp.rdata = rd;
			s_nxt.rsp.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		// A change in the same cycle as a clear wins
		for (int c = 0; c < NCH; c++) begin
			if (chg[c]) begin
				s_nxt.cf[c] = 1'b1; // [R3] [R12]
			end
			// Pending is a live AND, never latched on its own
			s_nxt.ir[c] = s_r.cf[c] && s_r.ie[c]; // [R9] [R10] [R11]
			// Maskable gating like any other source
			s_nxt.irq[c] = global_irq_enable && s_r.ir[c] &&
				(s_r.prio[c] > current_priority_threshold); // [R14]
		end
		// One transfer of each kind in flight at a time
		s_nxt.rsp.awready = !s_nxt.aw_have && !s_nxt.rsp.bvalid;
		s_nxt.rsp.wready = !s_nxt.w_have && !s_nxt.rsp.bvalid;
		s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
		// Pin and analog-side controls
		s_nxt.pins.compare_enable = s_nxt.en;
		s_nxt.pins.reference_select = s_nxt.rsel; // [R8]
		s_nxt.pins.dac_output_enable = s_nxt.dac_en;
		s_nxt.pins.result_output_pin_oe = s_nxt.oe; // [R4]
		s_nxt.pins.result_output_pin = lvl ^ s_r.pol; // [R5]
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.rsp.awready <= 1'b1;
			s_r.rsp.wready <= 1'b1;
			s_r.rsp.arready <= 1'b1;
			s_r.lv_prev <= {NCH{RESULT_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign axi_rsp = s_r.rsp;
	assign pins = s_r.pins;
	assign irq_req = s_r.irq;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	for (genvar g = 0; g < NCH; g++) begin : g_chk
		// Pending tracks flag and enable with one cycle lag
		property p_pend;
			s_r.cf[g] && s_r.ie[g] |=> s_r.ir[g];
		endproperty
		a_pend: assert property (p_pend) // [R10]
			else $error("pending not set by flag and enable");

		// Pending falls once flag or enable is low
		property p_pend_drop;
			!(s_r.cf[g] && s_r.ie[g]) |=> !s_r.ir[g];
		endproperty
		a_pend_drop: assert property (p_pend_drop) // [R11]
			else $error("pending held without flag and enable");

		// Result change sets the flag next cycle
		property p_change;
			chg[g] |=> s_r.cf[g];
		endproperty
		a_change: assert property (p_change) // [R3]
			else $error("change flag not set on toggle");

		// Flag stays set unless a control write arrives
		property p_keep;
			s_r.cf[g] && !(do_wr && s_r.aw_addr == ctrl_ofs[g])
				|=> s_r.cf[g];
		endproperty
		a_keep: assert property (p_keep) // [R12]
			else $error("change flag dropped without write");

		// Armed zero write with no new change clears the flag
		property p_clear;
			do_wr && s_r.aw_addr == ctrl_ofs[g] && s_r.w_strb0 &&
				!s_r.w_data[B_CF] && s_r.armed[g] && !chg[g]
				|=> !s_r.cf[g];
		endproperty
		a_clear: assert property (p_clear) // [R13]
			else $error("armed zero write did not clear flag");

		// Unarmed writes never clear the flag
		property p_noclr;
			do_wr && s_r.cf[g] && !s_r.armed[g] |=> s_r.cf[g];
		endproperty
		a_noclr: assert property (p_noclr) // [R13]
			else $error("flag cleared without prior read");

		// Pin enable and polarity-adjusted result follow the controls
		property p_pin;
			s_r.oe[g] ##1 s_r.oe[g] |-> pins.result_output_pin_oe[g] &&
				pins.result_output_pin[g] ==
				($past(lvl[g]) ^ $past(s_r.pol[g]));
		endproperty
		a_pin: assert property (p_pin) // [R4] [R5]
			else $error("result pin wrong");

		// Interrupt line ties to global enable, pending and priority
		property p_irq;
			irq_req[g] == $past(global_irq_enable && s_r.ir[g] &&
				s_r.prio[g] > current_priority_threshold);
		endproperty
		a_irq: assert property (p_irq) // [R14] [R9]
			else $error("interrupt gating wrong");

		c_flag: cover property (chg[g] ##1 s_r.cf[g]);
		c_irq: cover property (irq_req[g]);
		c_clear: cover property (s_r.cf[g] ##1 !s_r.cf[g]);
	end

	c_slverr: cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
endmodule

// ### test/cmp_analog_model.sv
// Behavioural analog compare element facing both comparator channels
`timescale 1ns/1ps
module cmp_analog_model (
	input wire logic aclk,
	input wire logic [1:0][7:0] vin,
	input wire logic [1:0][7:0] ref_pin,
	input wire logic [1:0][7:0] dac_lvl,
	input wire cmp_pkg::cmp_pins_t pins,
	output logic [1:0] raw_compare_result
);
	import cmp_pkg::*;
	logic noise_r; // Toggles every cycle, stands in for an undefined output

	// Free toggle so an undefined level never settles to a lucky value
	initial noise_r = 1'h0;
	always @(posedge aclk) begin
		noise_r <= ~noise_r;
	end

	// Compare each input against the selected reference
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			if (!pins.compare_enable[i]) begin
				raw_compare_result[i] = noise_r; // Powered down: no level
			end else if (pins.reference_select[i]) begin
				// DAC is a reference only while its output is on
				if (!pins.dac_output_enable[i] || vin[i] == dac_lvl[i]) begin
					raw_compare_result[i] = noise_r;
				end else begin
					raw_compare_result[i] = vin[i] > dac_lvl[i];
				end
			end else if (vin[i] == ref_pin[i]) begin
				raw_compare_result[i] = noise_r; // Tie gives no clean level
			end else begin
				raw_compare_result[i] = vin[i] > ref_pin[i]; // Pin
			end
		end
	end
endmodule

// ### test/test_comparator_result_interrupt_logic.sv
// Self-checking bench for the dual comparator block
`timescale 1ns/1ps
module test_comparator_result_interrupt_logic;
	import cmp_pkg::*;
	// One filter row: channel, filter, polarity, pulse length, flag expected
	typedef struct packed {
		logic ch;
		cmp_flt_t flt;
		logic pol;
		logic [7:0] len;
		logic exp;
	} cmp_row_t;
	localparam int SETTLE = 2000; // 10 us of settling at 5 ns
	logic aclk, aresetn, gie;
	logic [2:0] thr;
	cmp_axi_req_t req;
	cmp_axi_rsp_t rsp;
	cmp_pins_t pins;
	logic [1:0] raw, irq;
	logic [1:0][7:0] vin, vref, vdac;
	logic [31:0] rd_d;
	logic [1:0] rsp_c;
	logic [7:0] ofs;
	logic c;
	int error_cnt, tests_run;
	cmp_row_t rows [5] = '{'{1'h0, FLT_NONE, 1'h0, 8'h04, 1'h1},
		'{1'h1, FLT_F2, 1'h1, 8'h06, 1'h1},
		'{1'h0, FLT_F8, 1'h1, 8'h06, 1'h0},
		'{1'h1, FLT_F8, 1'h0, 8'h14, 1'h1},
		'{1'h0, FLT_F32, 1'h0, 8'h14, 1'h0}};
	logic [7:0] adr [6] = '{OFS_CTRL0, OFS_CTRL1, OFS_MODE, OFS_IRQC0,
		OFS_IRQC1, OFS_DAC};

	cmp_top u_cmp_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
		.axi_rsp(rsp), .raw_compare_result(raw), .global_irq_enable(gie),
		.current_priority_threshold(thr), .pins(pins), .irq_req(irq));
	cmp_analog_model u_cmp_analog_model (.aclk(aclk), .vin(vin),
		.ref_pin(vref), .dac_lvl(vdac), .pins(pins),
		.raw_compare_result(raw));

	// 200 MHz clock
	initial begin
		aclk = 1'h0;
		forever #2.5 aclk = ~aclk;
	end

	// Compare and count; unknowns never match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Counts, verdict and end of run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Ready is looked at mid-cycle, since inputs only move after edges
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ta, tw;
		@(posedge aclk);
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= d;
		req.bready <= 1'h1;
		pa = 1'h1;
		pw = 1'h1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && rsp.awready;
			tw = pw && rsp.wready;
			@(posedge aclk);
			if (ta) begin
				req.awvalid <= 1'h0;
				pa = 1'h0;
			end
			if (tw) begin
				req.wvalid <= 1'h0;
				pw = 1'h0;
			end
		end
		do @(negedge aclk); while (rsp.bvalid !== 1'h1);
		rsp_c = rsp.bresp;
		@(posedge aclk);
		req.bready <= 1'h0;
	endtask

	// Read one register; data and response kept in rd_d and rsp_c
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		do @(negedge aclk); while (rsp.arready !== 1'h1);
		@(posedge aclk);
		req.arvalid <= 1'h0;
		do @(negedge aclk); while (rsp.rvalid !== 1'h1);
		rd_d = rsp.rdata;
		rsp_c = rsp.rresp;
		@(posedge aclk);
		req.rready <= 1'h0;
	endtask

	// Control word from its fields
	function automatic logic [31:0] cv(input logic en, input logic oe,
		input logic rs, input cmp_flt_t f, input logic ie, input logic cf);
		cv = 32'h0;
		cv[B_EN] = en;
		cv[B_OE] = oe;
		cv[B_REF] = rs;
		cv[B_FLT +: 2] = f;
		cv[B_IE] = ie;
		cv[B_CF] = cf;
	endfunction

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge aclk);
		error_cnt++;
		stop_test();
	end

	// Main sequence
	initial begin
		aresetn = 1'h0;
		req = '0;
		req.wstrb = 4'hF;
		gie = 1'h0;
		thr = 3'h0;
		vin = '0;
		vref = {8'h64, 8'h64};
		vdac = '0;
		error_cnt = 0;
		tests_run = 0;
		wt(4);
		aresetn <= 1'h1;
		// Filter rows, alternating channels
		foreach (rows[k]) begin
			c = rows[k].ch;
			ofs = c ? OFS_CTRL1 : OFS_CTRL0;
			wr(OFS_MODE, 32'(rows[k].pol) << c);
			// Pin output stays off until after the dummy read
			wr(ofs, cv(1'h0, 1'h0, 1'h0, rows[k].flt, 1'h0, 1'h1));
			wr(ofs, cv(1'h1, 1'h0, 1'h0, rows[k].flt, 1'h0, 1'h1));
			vin[c] <= 8'h14;
			wt(SETTLE);
			rd(ofs); // Dummy read arms the clear
			wr(ofs, cv(1'h1, 1'h1, 1'h0, rows[k].flt, 1'h0, 1'h0));
			rd(ofs);
			chk(rd_d[B_LV], 32'h0);
			chk(rd_d[B_CF], 32'h0);
			chk(pins.result_output_pin[c], rows[k].pol);
			chk(pins.result_output_pin_oe[c], 32'h1);
			// Short excursion above the reference
			vin[c] <= 8'hC8;
			wt(rows[k].len);
			vin[c] <= 8'h14;
			wt(150);
			rd(ofs);
			chk(rd_d[B_CF], rows[k].exp);
			wr(ofs, 32'h0);
			chk(pins.result_output_pin_oe[c], 32'h0);
			$display("Filter row %0d done", k);
		end
		// Reference from pin, then from the DAC
		vin[1] <= 8'h64;
		vref[1] <= 8'h32;
		vdac[1] <= 8'h96;
		wr(OFS_CTRL1, cv(1'h1, 1'h0, 1'h0, FLT_NONE, 1'h0, 1'h1));
		wt(SETTLE);
		rd(OFS_CTRL1);
		chk(rd_d[B_LV], 32'h1);
		chk(pins.reference_select[1], 32'h0);
		// Reference only moves while the channel is off
		wr(OFS_CTRL1, cv(1'h0, 1'h0, 1'h1, FLT_NONE, 1'h0, 1'h1));
		wr(OFS_DAC, 32'h2); // DAC output on before use
		wr(OFS_CTRL1, cv(1'h1, 1'h0, 1'h1, FLT_NONE, 1'h0, 1'h1));
		wt(SETTLE);
		rd(OFS_CTRL1);
		chk(rd_d[B_LV], 32'h0);
		chk(pins.reference_select[1], 32'h1);
		chk(pins.dac_output_enable[1], 32'h1);
		$display("Reference select done");
		// Interrupt request, gating and flag clearing on channel 0
		vin[0] <= 8'h14;
		wr(OFS_CTRL0, cv(1'h1, 1'h0, 1'h0, FLT_NONE, 1'h0, 1'h1));
		wt(SETTLE);
		rd(OFS_CTRL0); // Dummy read
		wr(OFS_CTRL0, cv(1'h1, 1'h0, 1'h0, FLT_NONE, 1'h1, 1'h0));
		wr(OFS_IRQC0, 32'h5); // Priority set last
		gie <= 1'h1;
		thr <= 3'h2;
		wt(5);
		chk(irq[0], 32'h0);
		vin[0] <= 8'hC8;
		wt(20);
		chk(irq[0], 32'h1);
		rd(OFS_IRQC0);
		chk(rd_d[7:0], 32'h0D);
		thr <= 3'h5;
		wt(3);
		chk(irq[0], 32'h0); // Level not above threshold
		thr <= 3'h2;
		gie <= 1'h0;
		wt(3);
		chk(irq[0], 32'h0);
		gie <= 1'h1;
		wr(OFS_CTRL0, cv(1'h1, 1'h0, 1'h0, FLT_NONE, 1'h0, 1'h1));
		wt(3);
		chk(irq[0], 32'h0);
		rd(OFS_IRQC0);
		chk(rd_d[7:0], 32'h05);
		// Zero written with no control read before it
		wr(OFS_CTRL0, cv(1'h1, 1'h0, 1'h0, FLT_NONE, 1'h1, 1'h0));
		wt(3);
		chk(irq[0], 32'h1);
		rd(OFS_CTRL0);
		wr(OFS_CTRL0, cv(1'h1, 1'h0, 1'h0, FLT_NONE, 1'h1, 1'h1));
		rd(OFS_CTRL0);
		chk(rd_d[B_CF], 32'h1);
		wr(OFS_CTRL0, cv(1'h1, 1'h0, 1'h0, FLT_NONE, 1'h1, 1'h0));
		wt(3);
		chk(irq[0], 32'h0);
		rd(OFS_CTRL0);
		chk(rd_d[B_CF], 32'h0);
		$display("Interrupt test done");
		// Unmapped address is refused
		rd(8'h18);
		chk(rsp_c, RESP_SLVERR);
		chk(rd_d, 32'h0);
		wr(8'h18, 32'hFF);
		chk(rsp_c, RESP_SLVERR);
		$display("Unmapped access done");
		// Second reset in mid-run restores every register
		aresetn <= 1'h0;
		wt(4);
		aresetn <= 1'h1;
		chk(pins, 32'h0);
		chk(irq, 32'h0);
		foreach (adr[i]) begin
			rd(adr[i]);
			chk(rd_d, i < 2 ? CTRL_RST : 8'h00);
		end
		$display("Reset test done");
		stop_test();
	end
endmodule
